// ---- bench/rbcs_partner.sv ----
// Far-side model: reset pin pull-up, external reset source and boot straps
`timescale 1ns/1ns
module rbcs_partner #(
    parameter int HOLD_CYC = 50
) (
    input wire logic pclk,
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic ext_go,
    input wire logic [15:0] ext_len,
    input wire logic [3:0] strap_req,
    input wire logic strap_force,
    output logic pin_level,
    output logic [3:0] straps
);
    int low_cnt = 0;
    int hold_cnt = 0;
    logic prev_pin = 1'b0;
    initial straps = 4'h0;
    // Pulled up: high only while nobody pulls low
    assign pin_level = (pin_oe ? pin_out : 1'b1) & (low_cnt == 0);
    always @(posedge pclk) begin
        if (ext_go) begin
            low_cnt <= ext_len;
        end else if (low_cnt > 0) begin
            low_cnt <= low_cnt - 1;
        end
        prev_pin <= pin_level;
        // Margin covers the device's pin synchroniser
        if (pin_level && !prev_pin) begin
            hold_cnt <= HOLD_CYC + 8;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end
        if (hold_cnt == 0 || strap_force) begin
            straps <= strap_req;
        end
    end
endmodule // rbcs_partner

// ---- bench/tb_reset_boot_clock_sequencer.sv ----
// Self-checking bench for the reset, boot and clock sequencer
`timescale 1ns/1ns
`include "rbcs_cfg.svh"
module tb_reset_boot_clock_sequencer;
    import rbcs_pkg::*;
    localparam int DEV = 100;
    localparam int HOLD = 50;
    logic pclk = 0, presetn = 0, supply = 1, wdog = 0, ext_go = 0, force_s = 0;
    logic [3:0] strap = 4'h5;
    logic [15:0] ext_len = 16'h0000;
    logic [15:0] pv, pcfg;
    rbcs_apb_req_s req = '0;
    rbcs_apb_rsp_s rsp;
    logic pin, pin_oe, pin_out, irn, ov, co, co_oe, ready, irq, err;
    logic [3:0] boot_pins, boot;
    logic [1:0] sdiv;
    logic [31:0] rd;
    logic [7:0] cfgs[6] = '{8'h13, 8'h12, 8'h11, 8'h10, 8'h1C, 8'h15};
    int pers[6] = '{32, 16, 8, 4, 2, 4};
    int errors = 0, compares = 0, n;

    rbcs_top #(.DEV_PULSE_CYC(DEV), .BOOT_HOLD_CYC(HOLD)) dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .chip_reset_pin_in(pin), .chip_reset_pin_out(pin_out),
        .chip_reset_pin_oe(pin_oe), .io_supply_ok(supply), .boot_mode_pins(boot_pins), .wdog_bite(wdog),
        .internal_reset_n(irn), .outputs_valid(ov), .boot_mode(boot), .system_divider_select(sdiv),
        .clock_output_pin(co), .clock_output_oe(co_oe), .pll_config(pcfg), .pll_ready(ready), .irq(irq));
    rbcs_partner #(.HOLD_CYC(HOLD)) far (.pclk(pclk), .pin_oe(pin_oe), .pin_out(pin_out), .ext_go(ext_go),
        .ext_len(ext_len), .strap_req(strap), .strap_force(force_s), .pin_level(pin), .straps(boot_pins));

    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk);
        while (rsp.pready !== 1'b1);
        chk("pready", rsp.pready, 1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    // Counts cycles of the device's own low drive on the pin
    task automatic oe_len(output int len);
        len = 0;
        for (int i = 0; i < 20 && pin_oe !== 1'b1; i++) @(posedge pclk);
        while (pin_oe === 1'b1 && len < 90000) begin
            @(posedge pclk);
            len++;
        end
    endtask
    task automatic wait_up(output int len);
        len = 0;
        for (int i = 0; i < 900 && irn !== 1'b1; i++) @(posedge pclk);
        while (ov !== 1'b1 && len < 100) begin
            @(posedge pclk);
            len++;
        end
    endtask
    task automatic period(output int len);
        len = 0;
        for (int i = 0; i < 80 && co !== 1'b0; i++) @(posedge pclk);
        for (int i = 0; i < 80 && co !== 1'b1; i++) @(posedge pclk);
        while (co === 1'b1 && len < 80) begin
            @(posedge pclk);
            len++;
        end
        while (co === 1'b0 && len < 80) begin
            @(posedge pclk);
            len++;
        end
    endtask
    task automatic ext_rst(input logic [15:0] len);
        @(posedge pclk);
        ext_go <= 1'b1;
        ext_len <= len;
        @(posedge pclk);
        ext_go <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        errors++;
        complete_run();
    end
    initial begin
        void'($urandom(3));
        @(posedge pclk);
        strap <= 4'($urandom);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (290) @(posedge pclk);
        chk("osc_wait", pin_oe, 1);
        wait_up(n);
        chk("valid_delay", n, 32);
        chk("boot_latch", boot, strap);
        apb(0, `RBCS_OFF_CTRL, 0);
        chk("ctrl_reset", rd, 32'h0000_0003);
        chk("co_oe_reset", co_oe, 0);
        period(n);
        chk("clkout_reset", n, 32);
        $display("test startup done");
        for (int k = 0; k < 6; k++) begin
            apb(1, `RBCS_OFF_CTRL, {24'h00_0000, cfgs[k]});
            repeat (40) @(posedge pclk);
            period(n);
            chk("clkout_period", n, pers[k]);
            chk("sysdiv_port", sdiv, cfgs[k][1:0]);
        end
        chk("co_oe_on", co_oe, 1);
        $display("test clocks done");
        apb(1, `RBCS_OFF_ISTAT, 32'h0000_001F);
        apb(1, `RBCS_OFF_IMASK, 0);
        @(posedge pclk);
        wdog <= 1'b1;
        @(posedge pclk);
        wdog <= 1'b0;
        oe_len(n);
        chk("wdog_pulse", n, 512);
        wait_up(n);
        chk("valid_delay_wd", n, 32);
        apb(0, `RBCS_OFF_ISTAT, 0);
        chk("wdog_flag", rd[0], 1);
        chk("irq_masked", irq, 0);
        apb(1, `RBCS_OFF_IMASK, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("irq_on", irq, 1);
        apb(1, `RBCS_OFF_ISTAT, 32'h0000_001F);
        repeat (2) @(posedge pclk);
        chk("irq_off", irq, 0);
        $display("test watchdog done");
        apb(1, `RBCS_OFF_CTRL, 32'h0000_0030);
        oe_len(n);
        chk("dev_pulse", n, DEV);
        wait_up(n);
        ext_rst(10);
        n = 0;
        repeat (60) begin
            @(posedge pclk);
            if (irn !== 1'b1) n++;
        end
        chk("short_ext", n, 0);
        strap <= strap ^ 4'($urandom_range(1, 15));
        apb(1, `RBCS_OFF_ISTAT, 32'h0000_001F);
        ext_rst(40);
        for (int i = 0; i < 80 && irn !== 1'b0; i++) @(posedge pclk);
        chk("ext_reset", irn, 0);
        wait_up(n);
        chk("boot_relatch", boot, strap);
        apb(0, `RBCS_OFF_ISTAT, 0);
        chk("ext_flag", rd[2], 1);
        force_s <= 1'b1;
        strap <= ~strap;
        repeat (5) @(posedge pclk);
        force_s <= 1'b0;
        apb(0, `RBCS_OFF_ISTAT, 0);
        chk("strap_flag", rd[4], 1);
        $display("test resets done");
        supply <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("supply_oe", pin_oe, 1);
        chk("supply_rst", irn, 0);
        chk("pin_drive_low", pin_out, 0);
        supply <= 1'b1;
        wait_up(n);
        pv = 16'($urandom);
        for (int k = 0; k < 2; k++) begin
            apb(1, `RBCS_OFF_PLL, {16'h0000, pv});
            repeat (1985) @(posedge pclk);
            apb(0, `RBCS_OFF_STATUS, 0);
            chk("pll_early", rd[0], 0);
            repeat (20) @(posedge pclk);
            apb(0, `RBCS_OFF_STATUS, 0);
            chk("pll_lock", rd[0], 1);
            chk("pll_ready", ready, k);
            chk("pll_cfg", pcfg, pv);
        end
        apb(0, 12'h014, 0);
        chk("unmapped_err", err, 1);
        chk("unmapped_data", rd, 0);
        $display("test pll done");
        // Mid-run block reset must restore every power-up default
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pll_cfg_reset", pcfg, 0);
        chk("ready_reset", ready, 0);
        wait_up(n);
        chk("valid_delay_rst", n, 32);
        apb(0, `RBCS_OFF_CTRL, 0);
        chk("ctrl_rerun", rd, 32'h0000_0003);
        chk("co_oe_rerun", co_oe, 0);
        $display("test rerun done");
        complete_run();
    end
endmodule // tb_reset_boot_clock_sequencer

// ---- logic/rbcs_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the reset and boot sequencer
`ifndef RBCS_CFG_SVH
`define RBCS_CFG_SVH

`define RBCS_CLK_PERIOD_NS 10
`define RBCS_OSC_START_NS 3000
`define RBCS_OSC_START_CYC ((`RBCS_OSC_START_NS + `RBCS_CLK_PERIOD_NS - 1) / `RBCS_CLK_PERIOD_NS)
`define RBCS_DEV_PULSE_US 600
`define RBCS_DEV_PULSE_CYC ((`RBCS_DEV_PULSE_US * 1000) / `RBCS_CLK_PERIOD_NS)
`define RBCS_WDOG_PULSE_CYC 512
`define RBCS_EXT_LOW_MIN_CYC 32
`define RBCS_OUT_VALID_CYC 32
`define RBCS_BOOT_HOLD_CYC 14000
`define RBCS_PLL_LOCK_CYC 2000
`define RBCS_LOCKS_NEEDED 2'h2

`define RBCS_OFF_CTRL 12'h000
`define RBCS_OFF_PLL 12'h004
`define RBCS_OFF_STATUS 12'h008
`define RBCS_OFF_ISTAT 12'h00C
`define RBCS_OFF_IMASK 12'h010

`define RBCS_IDX_CTRL 3'h0
`define RBCS_IDX_PLL 3'h1
`define RBCS_IDX_STATUS 3'h2
`define RBCS_IDX_ISTAT 3'h3
`define RBCS_IDX_IMASK 3'h4
`define RBCS_IDX_BAD 3'h7

`define RBCS_CTRL_SYSDIV_LSB 0
`define RBCS_CTRL_CODIV_LSB 2
`define RBCS_CTRL_COEN_BIT 4
`define RBCS_CTRL_SWRST_BIT 5
`define RBCS_SYSDIV_RST 2'h3
`define RBCS_CODIV_RST 2'h0

`define RBCS_INT_WDOG 0
`define RBCS_INT_SWRST 1
`define RBCS_INT_EXT 2
`define RBCS_INT_PLL 3
`define RBCS_INT_BOOT 4

`endif

// ---- logic/rbcs_pkg.sv ----
// Types shared by the reset and boot sequencer
package rbcs_pkg;
    typedef enum logic [3:0] {
        ST_OSC = 4'b0001,
        ST_RESET = 4'b0010,
        ST_VALID = 4'b0100,
        ST_RUN = 4'b1000
    } rbcs_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rbcs_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rbcs_apb_rsp_s;

    typedef struct packed {
        rbcs_state_e st;
        logic [8:0] cnt;
        logic [16:0] pulse_cnt;
        logic [5:0] low_cnt;
        logic [15:0] hold_cnt;
        logic [2:0] pin_s;
        logic pin_f;
        logic [2:0] sup_s;
        logic sup_f;
        logic [3:0] boot_s1;
        logic [3:0] boot_s2;
        logic [3:0] boot_s3;
        logic [3:0] boot_f;
        logic [3:0] boot_lat;
        logic [1:0] sysdiv;
        logic [1:0] codiv;
        logic co_en;
        logic [15:0] pll_cfg;
        logic [10:0] lock_cnt;
        logic locked;
        logic [1:0] lock_n;
        logic ready;
        logic [4:0] int_stat;
        logic [4:0] int_mask;
        rbcs_apb_rsp_s rsp;
        logic rst_oe;
        logic int_rst_n;
        logic out_valid;
        logic irq;
        logic [4:0] div_cnt;
        logic clk_out;
    } rbcs_state_s;
endpackage

// ---- logic/rbcs_top.sv ----
// Reset pin sequencer, boot-mode capture, clock dividers and PLL lock timer behind APB
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "rbcs_cfg.svh"

module rbcs_top #(
    parameter int DEV_PULSE_CYC = `RBCS_DEV_PULSE_CYC,
    parameter int BOOT_HOLD_CYC = `RBCS_BOOT_HOLD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire rbcs_pkg::rbcs_apb_req_s apb_req,
    output rbcs_pkg::rbcs_apb_rsp_s apb_rsp,
    input wire logic chip_reset_pin_in,
    output logic chip_reset_pin_out,
    output logic chip_reset_pin_oe,
    input wire logic io_supply_ok,
    input wire logic [3:0] boot_mode_pins,
    input wire logic wdog_bite,
    output logic internal_reset_n,
    output logic outputs_valid,
    output logic [3:0] boot_mode,
    output logic [1:0] system_divider_select,
    output logic clock_output_pin,
    output logic clock_output_oe,
    output logic [15:0] pll_config,
    output logic pll_ready,
    output logic irq
);
    import rbcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] rbcs_dec(input logic [11:0] a);
        case (a)
            `RBCS_OFF_CTRL: return `RBCS_IDX_CTRL;
            `RBCS_OFF_PLL: return `RBCS_IDX_PLL;
            `RBCS_OFF_STATUS: return `RBCS_IDX_STATUS;
            `RBCS_OFF_ISTAT: return `RBCS_IDX_ISTAT;
            `RBCS_OFF_IMASK: return `RBCS_IDX_IMASK;
            default: return `RBCS_IDX_BAD;
        endcase
    endfunction

    // Field 0 is /4, 1 is /2, 2 and 3 are /1
    function automatic logic [2:0] rbcs_co_exp(input logic [1:0] f);
        return (f >= 2'h2) ? 3'h0 : 3'(2'h2 - f);
    endfunction

    rbcs_state_s s;
    rbcs_state_s n;
    logic setup;
    logic wr_en;
    logic [2:0] idx;
    logic wr_ctrl;
    logic wr_pll;
    logic sw_rst_req;
    logic reset_req;

    assign idx = rbcs_dec(apb_req.paddr);
    assign setup = apb_req.psel && !apb_req.penable;
    // Write lands only on the edge where the master sees pready
    assign wr_en = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite;
    assign wr_ctrl = wr_en && (idx == `RBCS_IDX_CTRL);
    assign wr_pll = wr_en && (idx == `RBCS_IDX_PLL);
    assign sw_rst_req = wr_ctrl && apb_req.pwdata[`RBCS_CTRL_SWRST_BIT];
    // Short external lows are glitches, not resets
    assign reset_req = s.rst_oe || (s.low_cnt >= 6'(`RBCS_EXT_LOW_MIN_CYC));

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [4:0] ev;
        logic [2:0] k;
        ev = '0;
        k = '0;
        n = s;

        // Three-stage synchronisers; a change counts when stages two and three agree
        n.pin_s = {s.pin_s[1:0], chip_reset_pin_in};
        if (s.pin_s[1] == s.pin_s[2]) begin
            n.pin_f = s.pin_s[2];
        end
        n.sup_s = {s.sup_s[1:0], io_supply_ok};
        if (s.sup_s[1] == s.sup_s[2]) begin
            n.sup_f = s.sup_s[2];
        end
        n.boot_s1 = boot_mode_pins;
        n.boot_s2 = s.boot_s1;
        n.boot_s3 = s.boot_s2;
        if (s.boot_s2 == s.boot_s3) begin
            n.boot_f = s.boot_s3;
        end

        // Reset pulse timer; a longer pending pulse is never shortened
        if (s.pulse_cnt != '0) begin
            n.pulse_cnt = s.pulse_cnt - 17'h0_001;
        end
        if (wdog_bite) begin
            ev[`RBCS_INT_WDOG] = 1'b1;
            if (n.pulse_cnt < 17'(`RBCS_WDOG_PULSE_CYC)) begin
                n.pulse_cnt = 17'(`RBCS_WDOG_PULSE_CYC);
            end
        end
        if (sw_rst_req) begin
            ev[`RBCS_INT_SWRST] = 1'b1;
            if (n.pulse_cnt < 17'(DEV_PULSE_CYC)) begin
                n.pulse_cnt = 17'(DEV_PULSE_CYC);
            end
        end

        // Length of the current low on the pin, saturating
        if (s.pin_f) begin
            n.low_cnt = '0;
        end else if (s.low_cnt < 6'(`RBCS_EXT_LOW_MIN_CYC)) begin
            n.low_cnt = s.low_cnt + 6'h01;
        end

        // Strap stability watch after release; one event per release
        if (s.hold_cnt != '0) begin
            n.hold_cnt = s.hold_cnt - 16'h0_001;
            if (s.boot_f != s.boot_lat) begin
                ev[`RBCS_INT_BOOT] = 1'b1;
                n.hold_cnt = '0;
            end
        end

        unique case (s.st)
            ST_OSC: begin
                // Nothing trusts the clock before the oscillator has settled
                if (s.cnt == '0) begin
                    n.st = ST_RESET;
                end else begin
                    n.cnt = s.cnt - 9'h001;
                end
            end
            ST_RESET: begin
                if (!s.rst_oe && s.pin_f) begin
                    n.st = ST_VALID;
                    n.int_rst_n = 1'b1;
                    n.boot_lat = s.boot_f;
                    n.cnt = 9'(`RBCS_OUT_VALID_CYC);
                    n.hold_cnt = 16'(BOOT_HOLD_CYC);
                end
            end
            ST_VALID: begin
                if (s.cnt == 9'h001) begin
                    n.st = ST_RUN;
                    n.out_valid = 1'b1;
                end else begin
                    n.cnt = s.cnt - 9'h001;
                end
            end
            ST_RUN: begin
            end
        endcase
        if ((s.st == ST_VALID || s.st == ST_RUN) && reset_req) begin
            n.st = ST_RESET;
            n.int_rst_n = 1'b0;
            n.out_valid = 1'b0;
            n.hold_cnt = '0;
            ev[`RBCS_INT_EXT] = !s.rst_oe;
        end
        // Pin is pulled low while oscillator settles, supply is low or a pulse runs
        n.rst_oe = (n.st == ST_OSC) || !s.sup_f || (n.pulse_cnt != '0);

        // Output clock divider from one free-running counter
        n.div_cnt = s.div_cnt + 5'h01;
        k = 3'(s.sysdiv) + rbcs_co_exp(s.codiv);
        // Total ratio one is not reachable from a flop; it gives /2
        n.clk_out = (k == '0) ? n.div_cnt[0] : n.div_cnt[3'(k - 3'h1)];

        // PLL lock timer
        if (s.lock_cnt != '0) begin
            n.lock_cnt = s.lock_cnt - 11'h001;
            if (s.lock_cnt == 11'h001) begin
                n.locked = 1'b1;
                ev[`RBCS_INT_PLL] = 1'b1;
                if (s.lock_n != `RBCS_LOCKS_NEEDED) begin
                    n.lock_n = s.lock_n + 2'h1;
                end
            end
        end

        // Register writes
        if (wr_ctrl) begin
            n.sysdiv = apb_req.pwdata[`RBCS_CTRL_SYSDIV_LSB +: 2];
            n.codiv = apb_req.pwdata[`RBCS_CTRL_CODIV_LSB +: 2];
            n.co_en = apb_req.pwdata[`RBCS_CTRL_COEN_BIT];
        end
        if (wr_pll) begin
            n.pll_cfg = apb_req.pwdata[15:0];
            n.lock_cnt = 11'(`RBCS_PLL_LOCK_CYC);
            n.locked = 1'b0;
            // A new setting needs its own pair of locks
            if (apb_req.pwdata[15:0] != s.pll_cfg) begin
                n.lock_n = '0;
            end
        end
        n.ready = n.locked && (n.lock_n == `RBCS_LOCKS_NEEDED);
        if (wr_en && idx == `RBCS_IDX_IMASK) begin
            n.int_mask = apb_req.pwdata[4:0];
        end
        // New events win over a same-cycle clear
        n.int_stat = s.int_stat | ev;
        if (wr_en && idx == `RBCS_IDX_ISTAT) begin
            n.int_stat = (s.int_stat & ~apb_req.pwdata[4:0]) | ev;
        end
        n.irq = |(n.int_stat & n.int_mask);

        // APB answer: one wait-free access cycle, read data captured at setup
        n.rsp.pready = setup;
        n.rsp.pslverr = setup && (idx == `RBCS_IDX_BAD);
        if (setup) begin
            case (idx)
                `RBCS_IDX_CTRL: n.rsp.prdata = {27'h000_0000, s.co_en, s.codiv, s.sysdiv};
                `RBCS_IDX_PLL: n.rsp.prdata = {16'h0000, s.pll_cfg};
                `RBCS_IDX_STATUS: n.rsp.prdata = {22'h00_0000, s.out_valid, s.rst_oe, s.boot_lat,
                                                  s.ready, s.lock_n, s.locked};
                `RBCS_IDX_ISTAT: n.rsp.prdata = {27'h000_0000, s.int_stat};
                `RBCS_IDX_IMASK: n.rsp.prdata = {27'h000_0000, s.int_mask};
                default: n.rsp.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= ST_OSC;
            s.cnt <= 9'(`RBCS_OSC_START_CYC - 1);
            s.sysdiv <= `RBCS_SYSDIV_RST;
            s.codiv <= `RBCS_CODIV_RST;
            s.rst_oe <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign apb_rsp = s.rsp;
    // Open-drain: the pin is only ever pulled low
    assign chip_reset_pin_out = 1'b0;
    assign chip_reset_pin_oe = s.rst_oe;
    assign internal_reset_n = s.int_rst_n;
    assign outputs_valid = s.out_valid;
    assign boot_mode = s.boot_lat;
    assign system_divider_select = s.sysdiv;
    assign clock_output_pin = s.clk_out;
    assign clock_output_oe = s.co_en;
    assign pll_config = s.pll_cfg;
    assign pll_ready = s.ready;
    assign irq = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_div_defaults:
        assert property ($rose(presetn) |-> s.sysdiv == 2'h3 && s.codiv == 2'h0)
        else $error("Dividers not at power-up values");
    a_clkout_gated:
        assert property ($rose(s.co_en) |-> $past(wr_ctrl))
        else $error("Clock output enabled without a write");
    a_por_drive:
        assert property (!s.sup_f |=> chip_reset_pin_oe ##1 !internal_reset_n)
        else $error("Reset pin released while supply low");
    a_boot_latch:
        assert property ($rose(s.int_rst_n) |-> boot_mode == $past(s.boot_f))
        else $error("Boot mode not taken at release");
    a_ext_filter:
        assert property (s.st == ST_RUN && !s.rst_oe && s.low_cnt < 6'h20 |=> s.int_rst_n)
        else $error("Short low on reset pin caused a reset");
    a_sw_pulse:
        assert property (sw_rst_req && s.pulse_cnt <= 17'h0_001 |=> s.pulse_cnt == 17'(DEV_PULSE_CYC))
        else $error("Device reset pulse length wrong");
    a_wdog_pulse:
        assert property (wdog_bite && !sw_rst_req && s.pulse_cnt <= 17'h0_001
                         |=> s.pulse_cnt == 17'h0_200 ##1 s.pulse_cnt == 17'h0_1FF && chip_reset_pin_oe)
        else $error("Watchdog reset pulse length wrong");
    a_valid_delay:
        assert property ($rose(s.out_valid) |-> $past(s.int_rst_n, 32) && !$past(s.int_rst_n, 33))
        else $error("Outputs valid not 32 cycles after release");
    a_osc_wait:
        assert property ($fell(s.st == ST_OSC) |-> $past(s.cnt) == 9'h000 && !internal_reset_n)
        else $error("Oscillator wait cut short");
    a_lock_second:
        assert property ($rose(s.ready) |-> $past(s.lock_n) != 2'h0 && s.lock_n == 2'h2 && s.locked)
        else $error("PLL ready before the second lock");
    a_lock_time:
        assert property (wr_pll |=> !s.locked && s.lock_cnt == 11'h7D0)
        else $error("PLL lock timer not restarted");
    a_rel_sync:
        assert property ($rose(s.int_rst_n) |-> $past(s.pin_f) && !$past(s.rst_oe))
        else $error("Release not taken from the synchronised pin");
    a_sysdiv_write:
        assert property (wr_ctrl |=> s.sysdiv == $past(apb_req.pwdata[`RBCS_CTRL_SYSDIV_LSB +: 2]))
        else $error("System divider select not taken from the write");
    a_co_off_reset:
        assert property ($rose(presetn) |-> !clock_output_oe)
        else $error("Clock output enabled out of reset");
    a_pulse_runs:
        assert property (s.pulse_cnt != 17'h0_000 |-> chip_reset_pin_oe)
        else $error("Reset pin released while a pulse runs");
    a_pulse_shrink:
        assert property (s.pulse_cnt > 17'h0_001 |=> s.pulse_cnt >= $past(s.pulse_cnt) - 17'h0_001)
        else $error("Pending reset pulse was shortened");
    a_wdog_event:
        assert property (wdog_bite |=> s.int_stat[`RBCS_INT_WDOG])
        else $error("Watchdog event not flagged");
    a_osc_hold:
        assert property (s.st == ST_OSC |-> chip_reset_pin_oe && !internal_reset_n)
        else $error("Reset released during oscillator wait");
    a_valid_low:
        assert property (!s.int_rst_n |-> !s.out_valid)
        else $error("Outputs valid while in reset");
    a_lock_wait:
        assert property (s.lock_cnt != 11'h000 |-> !s.locked && !s.ready)
        else $error("PLL flagged locked while the timer runs");
    a_boot_stable:
        assert property (s.st == ST_RUN |-> boot_mode == $past(boot_mode))
        else $error("Boot mode changed outside a release");
    a_sup_sync:
        assert property ($fell(s.sup_f) |-> $past(s.sup_s[1]) == 1'b0 && $past(s.sup_s[2]) == 1'b0)
        else $error("Supply drop taken before the synchroniser agreed");
    a_pin_sync:
        assert property ($changed(s.pin_f) |-> $past(s.pin_s[1]) == $past(s.pin_s[2]))
        else $error("Pin level taken before the synchroniser agreed");
    a_ext_reset:
        assert property (s.st == ST_RUN && !s.rst_oe && s.low_cnt >= 6'h20 |=> !s.int_rst_n && s.int_stat[`RBCS_INT_EXT])
        else $error("Long external low did not reset");
endmodule // rbcs_top
